// File: rtl/pic_defs.vh
// Constants of the prioritized interrupt controller.
`ifndef PIC_DEFS_VH
`define PIC_DEFS_VH

// --------------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------------
`define PIC_OFF_LATCH_LO 8'h00
`define PIC_OFF_LATCH_HI 8'h04
`define PIC_OFF_ENABLE_LO 8'h08
`define PIC_OFF_ENABLE_HI 8'h0c
`define PIC_OFF_PRIO_LO 8'h10
`define PIC_OFF_PRIO_HI 8'h14
`define PIC_OFF_SYSCTL 8'h18
`define PIC_OFF_STATUS 8'h1c

// --------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------
`define PIC_BIT_MASTER 0
`define PIC_BIT_VEC_AREA 0
`define PIC_BIT_RAM_AREA 1
`define PIC_BIT_WDT_SEL 2
`define PIC_BIT_WDT 3
`define PIC_FIRST_MASKABLE 4
`define PIC_LAST_SOURCE 35
`define PIC_SRC_SOFTWARE 6'h00
`define PIC_SRC_UNDEFINED 6'h01
`define PIC_SRC_WATCHDOG 6'h03

// --------------------------------------------------------------------
// Masks and reset values
// --------------------------------------------------------------------
`define PIC_LATCH_MASK 36'hf_ffff_77f8
`define PIC_CLEAR_MASK 36'hf_ffff_77f0
`define PIC_ENABLE_MASK 36'hf_ffff_77f0
`define PIC_LATCH_RST 36'h0_0000_0000
`define PIC_ENABLE_RST 36'h0_0000_0000
`define PIC_PRIO_RST 64'h0000_0000_0000_0000
`define PIC_SYSCTL_RST 3'h4
`define PIC_STACK_DEPTH 8

// --------------------------------------------------------------------
// Vectors and bus responses
// --------------------------------------------------------------------
`define PIC_VEC_RESET 16'hfffe
`define PIC_VEC_HI_ROM 8'hff
`define PIC_VEC_HI_RAM 8'h01
`define PIC_VEC_TRAP 8'hfc
`define PIC_VEC_WDT 8'hf8
`define PIC_VEC_BASE_A 8'hfe
`define PIC_VEC_BASE_B 8'hde
`define PIC_RESP_OKAY 2'h0
`define PIC_RESP_SLVERR 2'h2

`endif

// File: rtl/pic_ctrl.v
// Prioritized interrupt controller with an AXI4-Lite register slave.
//
// How it works
// - 33 sources besides reset; requests may nest within a service.
// - Software, undefined-opcode and watchdog requests are non-maskable, all else maskable.
// - A raised request sets its latch, a watchdog one only with reset output unselected; a set latch requests the CPU unless masked.
// - Maskable request accepted only when master and source enable flags are set.
// - Pending maskable requests are accepted one at a time, highest first.
// - Priority is decided by programmed level first, then by basic priority.
// - Basic priority follows source number, watchdog and traps ahead of all.
// - Non-maskable sources are ranked software first, then undefined opcode, then watchdog.
// - Both traps share vector low byte 0xfc; every other source has its own, two bytes apart per bank.
// - Area select picks 0xffxx or 0x01xx; reset vector stays 0xfffe.
// - No vector points at option bytes 0xfffa and 0xfffb.
// - A latch clears as soon as the CPU accepts its interrupt.
// - Acceptance pushes and clears the master flag; return pops it back.
// - Writing 1 to a latch keeps it, writing 0 clears it, except the watchdog latch.
// - Non-maskable requests ignore every enable flag.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "pic_defs.vh"

module pic_ctrl (
    // Clock and reset
    input wire clock_i,
    input wire arst_n_i,
    // Interrupt sources, one-cycle pulses, and the serial programming mode level
    input wire [35:0] irq_i,
    input wire software_irq_i,
    input wire undefined_opcode_irq_i,
    input wire serial_prog_mode_i,
    // CPU core side
    input wire cpu_accept_i,
    input wire cpu_return_i,
    output reg irq_req_o,
    output reg [5:0] irq_source_o,
    output reg [15:0] irq_vector_o,
    output reg [15:0] reset_vector_o,
    output reg vector_in_ram_o,
    output reg watchdog_reset_o,
    // AXI4-Lite write address and data
    input wire [7:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output reg s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output reg s_axi_wready_o,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    // AXI4-Lite read
    input wire [7:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output reg s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i
);
    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [31:0] be;
        begin
            merge = (old & ~be) | (data & be);
        end
    endfunction
    // Vector low byte; 0xfa stays free for option codes.
    function [7:0] vec_low;
        input [5:0] src;
        begin
            if (src <= `PIC_SRC_UNDEFINED) begin
                vec_low = `PIC_VEC_TRAP;
            end else if (src == `PIC_SRC_WATCHDOG) begin
                vec_low = `PIC_VEC_WDT;
            end else if (src < 6'h20) begin
                vec_low = `PIC_VEC_BASE_A - {1'b0, src, 1'b0};
            end else begin
                vec_low = `PIC_VEC_BASE_B - {1'b0, src, 1'b0};
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg [35:0] request_latch;
    reg [35:0] source_enable_flag;
    reg master_enable_flag;
    reg [`PIC_STACK_DEPTH-1:0] imf_stack;
    reg [63:0] priority_level_regs;
    reg vector_area_select, ram_area_select, watchdog_output_select;
    reg software_pend, undefined_pend;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    localparam [35:0] latch_mask = `PIC_LATCH_MASK;
    localparam [35:0] enable_mask = `PIC_ENABLE_MASK;
    localparam [2:0] sysctl_rst = `PIC_SYSCTL_RST;

    // ----------------------------------------------------------------
    // Register write decode
    // ----------------------------------------------------------------
    wire do_write = ~s_axi_awready_o & ~s_axi_wready_o & ~s_axi_bvalid_o;
    wire [31:0] be = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}},
        {8{w_strb[0]}}};
    wire wr_latch_lo = do_write && aw_addr[7:2] == `PIC_OFF_LATCH_LO >> 2;
    wire wr_latch_hi = do_write && aw_addr[7:2] == `PIC_OFF_LATCH_HI >> 2;
    wire wr_en_lo = do_write && aw_addr[7:2] == `PIC_OFF_ENABLE_LO >> 2;
    wire wr_en_hi = do_write && aw_addr[7:2] == `PIC_OFF_ENABLE_HI >> 2;
    wire wr_prio_lo = do_write && aw_addr[7:2] == `PIC_OFF_PRIO_LO >> 2;
    wire wr_prio_hi = do_write && aw_addr[7:2] == `PIC_OFF_PRIO_HI >> 2;
    wire wr_sysctl = do_write && aw_addr[7:2] == `PIC_OFF_SYSCTL >> 2;
    wire wr_mapped = wr_latch_lo | wr_latch_hi | wr_en_lo | wr_en_hi |
        wr_prio_lo | wr_prio_hi | wr_sysctl;
    wire [31:0] clr_lo = wr_latch_lo ? (~w_data & be) : 32'h0000_0000;
    wire [3:0] clr_hi = wr_latch_hi ? (~w_data[3:0] & be[3:0]) : 4'h0;
    wire [35:0] clr_sw = {clr_hi, clr_lo} & `PIC_CLEAR_MASK;
    wire accepting = irq_req_o & cpu_accept_i;
    wire [31:0] en_lo_new = merge({source_enable_flag[31:1],
        master_enable_flag}, w_data, be);
    wire [31:0] en_hi_new = merge({28'h000_0000,
        source_enable_flag[35:32]}, w_data, be);

    // ----------------------------------------------------------------
    // Request latches
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 36; g = g + 1) begin : g_latch
            wire set_req = irq_i[g] & latch_mask[g] &
                ~(g == `PIC_BIT_WDT && watchdog_output_select);
            wire clr_acc = accepting && irq_source_o == g;
            // A new request wins over a clear in the same cycle.
            always @(posedge clock_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    request_latch[g] <= 1'b0;
                end else if (set_req) begin
                    request_latch[g] <= 1'b1;
                end else if (clr_acc || clr_sw[g]) begin
                    request_latch[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Enables, master flag stack, levels and system control
    // ----------------------------------------------------------------
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            source_enable_flag <= `PIC_ENABLE_RST;
            master_enable_flag <= 1'b0;
            imf_stack <= {`PIC_STACK_DEPTH{1'b0}};
            priority_level_regs <= `PIC_PRIO_RST;
            vector_area_select <= sysctl_rst[`PIC_BIT_VEC_AREA];
            ram_area_select <= sysctl_rst[`PIC_BIT_RAM_AREA];
            watchdog_output_select <= sysctl_rst[`PIC_BIT_WDT_SEL];
        end else begin
            if (wr_en_lo) begin
                source_enable_flag[31:0] <= en_lo_new & enable_mask[31:0];
            end
            if (wr_en_hi) begin
                source_enable_flag[35:32] <= en_hi_new[3:0];
            end
            // Acceptance beats a software write; return restores the flag.
            if (accepting) begin
                imf_stack <= {imf_stack[`PIC_STACK_DEPTH-2:0],
                    master_enable_flag};
                master_enable_flag <= 1'b0;
            end else if (cpu_return_i) begin
                master_enable_flag <= imf_stack[0];
                imf_stack <= {1'b0, imf_stack[`PIC_STACK_DEPTH-1:1]};
            end else if (wr_en_lo) begin
                master_enable_flag <= en_lo_new[`PIC_BIT_MASTER];
            end
            if (wr_prio_lo) begin
                priority_level_regs[31:0] <=
                    merge(priority_level_regs[31:0], w_data, be);
            end
            if (wr_prio_hi) begin
                priority_level_regs[63:32] <=
                    merge(priority_level_regs[63:32], w_data, be);
            end
            if (wr_sysctl && w_strb[0]) begin
                vector_area_select <= w_data[`PIC_BIT_VEC_AREA];
                ram_area_select <= w_data[`PIC_BIT_RAM_AREA];
                watchdog_output_select <= w_data[`PIC_BIT_WDT_SEL];
            end
        end
    end
    // Trap requests come from instructions and have no visible latch.
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            software_pend <= 1'b0;
            undefined_pend <= 1'b0;
        end else begin
            if (software_irq_i) begin
                software_pend <= 1'b1;
            end else if (accepting && irq_source_o == `PIC_SRC_SOFTWARE) begin
                software_pend <= 1'b0;
            end
            if (undefined_opcode_irq_i) begin
                undefined_pend <= 1'b1;
            end else if (accepting &&
                irq_source_o == `PIC_SRC_UNDEFINED) begin
                undefined_pend <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Arbitration
    // ----------------------------------------------------------------
    reg [5:0] best_src;
    reg best_valid;
    reg [1:0] best_lvl, lvl;
    integer i;
    always @* begin
        best_src = 6'h00;
        best_valid = 1'b0;
        best_lvl = 2'h3;
        lvl = 2'h0;
        // Descending scan so the lowest source number wins a tie.
        for (i = `PIC_LAST_SOURCE; i >= `PIC_FIRST_MASKABLE; i = i - 1) begin
            lvl = priority_level_regs[(i - `PIC_FIRST_MASKABLE) * 2 +: 2];
            if (request_latch[i] && source_enable_flag[i] &&
                master_enable_flag) begin
                if (!best_valid || lvl <= best_lvl) begin
                    best_src = i[5:0];
                    best_lvl = lvl;
                    best_valid = 1'b1;
                end
            end
        end
        // Non-maskable requests bypass all enables and outrank the rest.
        if (request_latch[`PIC_BIT_WDT]) begin
            best_src = `PIC_SRC_WATCHDOG;
            best_valid = 1'b1;
        end
        if (undefined_pend) begin
            best_src = `PIC_SRC_UNDEFINED;
            best_valid = 1'b1;
        end
        if (software_pend) begin
            best_src = `PIC_SRC_SOFTWARE;
            best_valid = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // CPU side outputs
    // ----------------------------------------------------------------
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_req_o <= 1'b0;
            irq_source_o <= 6'h00;
            irq_vector_o <= `PIC_VEC_RESET;
            reset_vector_o <= `PIC_VEC_RESET;
            vector_in_ram_o <= 1'b0;
            watchdog_reset_o <= 1'b0;
        end else begin
            // The request drops for the cycle after an acceptance.
            irq_req_o <= best_valid & ~accepting;
            if (!accepting) begin
                irq_source_o <= best_src;
                irq_vector_o <= {vector_area_select ? `PIC_VEC_HI_RAM :
                    `PIC_VEC_HI_ROM, vec_low(best_src)};
            end
            reset_vector_o <= `PIC_VEC_RESET;
            vector_in_ram_o <= vector_area_select & ram_area_select;
            watchdog_reset_o <= irq_i[`PIC_BIT_WDT] & watchdog_output_select;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `PIC_RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awready_o && s_axi_awvalid_i) begin
                aw_addr <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wready_o && s_axi_wvalid_i) begin
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_mapped ? `PIC_RESP_OKAY :
                    `PIC_RESP_SLVERR;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    reg [31:0] rd_mux;
    reg rd_hit;
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr_i[7:2])
            `PIC_OFF_LATCH_LO >> 2: rd_mux = request_latch[31:0];
            `PIC_OFF_LATCH_HI >> 2: rd_mux = {28'h000_0000,
                request_latch[35:32]};
            `PIC_OFF_ENABLE_LO >> 2: rd_mux = {source_enable_flag[31:1],
                master_enable_flag};
            `PIC_OFF_ENABLE_HI >> 2: rd_mux = {28'h000_0000,
                source_enable_flag[35:32]};
            `PIC_OFF_PRIO_LO >> 2: rd_mux = priority_level_regs[31:0];
            `PIC_OFF_PRIO_HI >> 2: rd_mux = priority_level_regs[63:32];
            `PIC_OFF_SYSCTL >> 2: rd_mux = {29'h0000_0000,
                watchdog_output_select, ram_area_select,
                vector_area_select};
            `PIC_OFF_STATUS >> 2: rd_mux = {irq_vector_o, 2'h0,
                irq_source_o, 6'h00, serial_prog_mode_i, irq_req_o};
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `PIC_RESP_OKAY;
        end else begin
            if (s_axi_arready_o && s_axi_arvalid_i) begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= rd_mux;
                s_axi_rresp_o <= rd_hit ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
            end
            if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
                s_axi_arready_o <= 1'b1;
            end
        end
    end
endmodule // pic_ctrl

// File: tb/pic_ctrl_sva.sv
// Concurrent checks on the interrupt controller's CPU link.
`timescale 1ns/1ps
module pic_ctrl_sva (
    // Clock and reset
    input wire clock_i,
    input wire arst_n_i,
    // Watched ports
    input wire [35:0] irq_i,
    input wire software_irq_i,
    input wire undefined_opcode_irq_i,
    input wire cpu_accept_i,
    input wire irq_req_o,
    input wire [5:0] irq_source_o,
    input wire [15:0] irq_vector_o,
    input wire [15:0] reset_vector_o,
    input wire watchdog_reset_o
);
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);
    wire [7:0] low = irq_vector_o[7:0];
    wire [7:0] twice = {1'b0, irq_source_o, 1'b0};
    wire maskable = irq_req_o && irq_source_o >= 6'd4;
    sequence s_trap;
        (software_irq_i || undefined_opcode_irq_i) ##1 !cpu_accept_i;
    endsequence
    sequence s_take;
        cpu_accept_i && irq_req_o;
    endsequence
    reset_vec_a: assert property (reset_vector_o == 16'hfffe)
        else $error("reset vector changed");
    idle_start_a: assert property ($rose(arst_n_i) |-> !irq_req_o)
        else $error("request pending right after reset");
    accept_drop_a: assert property (
        s_take |=> !irq_req_o && $stable(irq_source_o))
        else $error("request not dropped on acceptance");
    nmi_req_a: assert property (s_trap |=> irq_req_o)
        else $error("trap request not raised");
    trap_vec_a: assert property (
        irq_req_o && irq_source_o <= 6'd1 |-> low == 8'hfc)
        else $error("wrong trap vector");
    wdt_vec_a: assert property (
        irq_req_o && irq_source_o == 6'd3 |-> low == 8'hf8)
        else $error("wrong watchdog vector");
    mask_vec_a: assert property (
        maskable |-> low == (irq_source_o < 6'd32 ? 8'hfe : 8'hde) - twice)
        else $error("wrong maskable vector");
    option_a: assert property (
        irq_req_o |-> low != 8'hfa && low != 8'hfb)
        else $error("vector points at option bytes");
    src_range_a: assert property (
        irq_req_o |-> irq_source_o <= 6'd35 && irq_source_o != 6'd2
            && irq_source_o != 6'd11 && irq_source_o != 6'd15)
        else $error("request from a missing source");
    wdt_pulse_a: assert property (watchdog_reset_o |-> $past(irq_i[3]))
        else $error("watchdog reset without a watchdog event");
endmodule // pic_ctrl_sva

bind pic_ctrl pic_ctrl_sva i_pic_ctrl_sva (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .irq_i(irq_i),
    .software_irq_i(software_irq_i),
    .undefined_opcode_irq_i(undefined_opcode_irq_i),
    .cpu_accept_i(cpu_accept_i), .irq_req_o(irq_req_o),
    .irq_source_o(irq_source_o), .irq_vector_o(irq_vector_o),
    .reset_vector_o(reset_vector_o), .watchdog_reset_o(watchdog_reset_o)
);

// File: tb/pic_cpu_model.sv
// Behavioural CPU core that takes requests and returns from service.
`timescale 1ns/1ps
module pic_cpu_model (
    // Clock and reset
    input wire clock_i,
    input wire arst_n_i,
    // Controller side
    input wire irq_req_i,
    input wire [5:0] irq_source_i,
    input wire [15:0] irq_vector_i,
    output reg accept_o,
    output reg return_o,
    // Bench control
    input wire [3:0] delay_i,
    input wire enable_i,
    input wire auto_ret_i,
    input wire ret_i,
    // Log of the last accepted request
    output reg [5:0] last_src_o,
    output reg [15:0] last_vec_o,
    output reg [7:0] count_o
);
    // ----------------------------------------------------------------
    // Acceptance after a programmable delay, return after service
    // ----------------------------------------------------------------
    reg [3:0] wait_cnt;
    reg [1:0] ret_pipe;
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            accept_o <= 1'b0;
            return_o <= 1'b0;
            last_src_o <= 6'h00;
            last_vec_o <= 16'h0000;
            count_o <= 8'h00;
            wait_cnt <= 4'h0;
            ret_pipe <= 2'h0;
        end else begin
            return_o <= ret_pipe[1] | ret_i;
            ret_pipe <= {ret_pipe[0], 1'b0};
            if (accept_o) begin
                accept_o <= 1'b0;
                if (irq_req_i) begin
                    last_src_o <= irq_source_i;
                    last_vec_o <= irq_vector_i;
                    count_o <= count_o + 8'h01;
                    ret_pipe <= {ret_pipe[0], auto_ret_i};
                end
            end else if (enable_i && irq_req_i) begin
                accept_o <= (wait_cnt == delay_i);
                wait_cnt <= (wait_cnt == delay_i) ? 4'h0 : wait_cnt + 4'h1;
            end
        end
    end
endmodule // pic_cpu_model

// File: tb/pic_ctrl_bench.sv
// Self-checking bench for the prioritized interrupt controller.
`timescale 1ns/1ps
`include "pic_defs.vh"
module pic_ctrl_bench;
    // ----------------------------------------------------------------
    // Signals, instances and bus tasks
    // ----------------------------------------------------------------
    reg clock_i;
    reg arst_n = 1'b0, spm = 1'b0, en = 1'b0, auto = 1'b0, ret = 1'b0;
    reg sw = 1'b0, ud = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    reg bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg [35:0] irq = 36'h0;
    reg [3:0] dly = 4'h0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00, c;
    reg [31:0] wdata = 32'h0, d;
    reg [1:0] r;
    integer err_total = 0, comparisons = 0, wdt_seen = 0, n;
    wire acc, rtn, req, in_ram, wdt, awready, wready, bvalid, arready, rvalid;
    wire [5:0] src, lsrc;
    wire [15:0] vec, rvec, lvec;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] cnt;
    pic_ctrl i_pic_ctrl (
        .clock_i(clock_i), .arst_n_i(arst_n), .irq_i(irq),
        .software_irq_i(sw), .undefined_opcode_irq_i(ud),
        .serial_prog_mode_i(spm), .cpu_accept_i(acc), .cpu_return_i(rtn),
        .irq_req_o(req), .irq_source_o(src), .irq_vector_o(vec),
        .reset_vector_o(rvec), .vector_in_ram_o(in_ram),
        .watchdog_reset_o(wdt), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready)
    );
    pic_cpu_model i_pic_cpu_model (
        .clock_i(clock_i), .arst_n_i(arst_n), .irq_req_i(req),
        .irq_source_i(src), .irq_vector_i(vec), .accept_o(acc),
        .return_o(rtn), .delay_i(dly), .enable_i(en), .auto_ret_i(auto),
        .ret_i(ret), .last_src_o(lsrc), .last_vec_o(lvec), .count_o(cnt)
    );
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    always @(posedge clock_i) if (wdt === 1'b1) wdt_seen <= wdt_seen + 1;
    task chk(input [35:0] s, input [35:0] e);
        comparisons = comparisons + 1;
        if (s !== e) begin
            err_total = err_total + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task cyc(input integer k);
        repeat (k) @(posedge clock_i);
    endtask
    task pulse(input [37:0] m);
        {ud, sw, irq} <= m;
        cyc(1);
        {ud, sw, irq} <= 38'h0;
        cyc(1);
    endtask
    task wait_acc(input [5:0] s, input [15:0] v);
        c = cnt;
        for (n = 0; n < 200 && cnt === c; n = n + 1) cyc(1);
        chk(cnt, c + 8'h01);
        chk({lsrc, lvec}, {s, v});
    endtask
    task wr(input [7:0] a, input [31:0] dt, output [1:0] rs);
        awaddr <= a;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock_i);
            if (awvalid & awready) awvalid <= 1'b0;
            if (wvalid & wready) wvalid <= 1'b0;
            if (bready & bvalid) begin
                bready <= 1'b0;
                rs = bresp;
            end
        end while (awvalid | wvalid | bready);
    endtask
    task rd(input [7:0] a, output [31:0] dt, output [1:0] rs);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock_i);
            if (arvalid & arready) arvalid <= 1'b0;
            if (rready & rvalid) begin
                rready <= 1'b0;
                dt = rdata;
                rs = rresp;
            end
        end while (arvalid | rready);
    endtask
    task wrok(input [7:0] a, input [31:0] dt);
        wr(a, dt, r);
        chk(r, `PIC_RESP_OKAY);
    endtask
    task rdchk(input [7:0] a, input [31:0] e);
        rd(a, d, r);
        chk({r, d}, {`PIC_RESP_OKAY, e});
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reset;
        rdchk(`PIC_OFF_LATCH_LO, 32'h0);
        rdchk(`PIC_OFF_ENABLE_LO, 32'h0);
        rdchk(`PIC_OFF_SYSCTL, 32'h4);
        chk({req, rvec}, {1'b0, 16'hfffe});
        rd(8'h20, d, r);
        chk({r, d}, {`PIC_RESP_SLVERR, 32'h0});
        wr(8'h24, 32'h1, r);
        chk(r, `PIC_RESP_SLVERR);
        $display("test reset done");
    endtask
    task t_latch;
        pulse(38'h10);
        cyc(3);
        chk(req, 1'b0);
        rdchk(`PIC_OFF_LATCH_LO, 32'h10);
        wrok(`PIC_OFF_LATCH_LO, 32'hffff_ffff);
        rdchk(`PIC_OFF_LATCH_LO, 32'h10);
        wrok(`PIC_OFF_LATCH_LO, 32'hffff_ffef);
        rdchk(`PIC_OFF_LATCH_LO, 32'h0);
        wrok(`PIC_OFF_ENABLE_LO, 32'h11);
        en <= 1'b1;
        pulse(38'h10);
        wait_acc(6'd4, 16'hfff6);
        rdchk(`PIC_OFF_LATCH_LO, 32'h0);
        rdchk(`PIC_OFF_ENABLE_LO, 32'h10);
        ret <= 1'b1;
        cyc(1);
        ret <= 1'b0;
        cyc(2);
        rdchk(`PIC_OFF_ENABLE_LO, 32'h11);
        $display("test latch done");
    endtask
    task t_prio;
        auto <= 1'b1;
        dly <= 4'h5;
        wrok(`PIC_OFF_SYSCTL, 32'h3);
        wrok(`PIC_OFF_PRIO_LO, 32'h1);
        wrok(`PIC_OFF_ENABLE_HI, 32'h8);
        wrok(`PIC_OFF_ENABLE_LO, 32'h31);
        pulse(38'h8_0000_0030);
        wait_acc(6'd5, 16'h01f4);
        wait_acc(6'd35, 16'h0198);
        wait_acc(6'd4, 16'h01f6);
        chk(in_ram, 1'b1);
        $display("test priority done");
    endtask
    task t_nmi;
        wrok(`PIC_OFF_ENABLE_LO, 32'h0);
        wrok(`PIC_OFF_SYSCTL, 32'h4);
        pulse(38'h8);
        cyc(3);
        chk({wdt_seen[3:0], req}, {4'h1, 1'b0});
        wrok(`PIC_OFF_SYSCTL, 32'h0);
        pulse(38'h8);
        wait_acc(6'd3, 16'hfff8);
        pulse(38'h10_0000_0000);
        wait_acc(6'd0, 16'hfffc);
        spm <= 1'b1;
        wrok(`PIC_OFF_SYSCTL, 32'h1);
        pulse(38'h20_0000_0000);
        wait_acc(6'd1, 16'h01fc);
        c = cnt;
        pulse(38'h30_0000_0000);
        cyc(30);
        chk(cnt, c + 8'h02);
        rdchk(`PIC_OFF_STATUS, 32'h01fc_0002);
        $display("test non-maskable done");
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock_i);
        arst_n <= 1'b1;
        cyc(1);
        t_reset;
        t_latch;
        t_prio;
        t_nmi;
        final_report;
    end
    initial begin
        #100000;
        err_total = err_total + 1;
        final_report;
    end
endmodule // pic_ctrl_bench
